// ===== common/tsec_pkg.sv
// Purpose: Shared constants and carrier types of the two-stage event controller
// Assumes: 24 peripheral sources, 16 core event levels, one core clock
// Notes:   Register indices are word indices on the register port
// Operation
// RQ1: Sixteen ranked levels, 0 highest, general interrupts at levels 7 to 15.
// RQ2: Higher events nest over active lower ones; several routines active at once.
// RQ3: Core stage has nine general inputs at levels 7 to 15.
// RQ4: Software should keep levels 14 and 15 for software handlers.
// RQ5: Every peripheral source routes to one general input via assignment registers.
// RQ6: Reset routing follows the default table of levels 7 to 13.
// RQ7: Rising edge on a core input sets its latch bit within two cycles.
// RQ8: Latch bit clears when the same event's active bit sets.
// RQ9: After acceptance, the next rising edge on that input queues again.
// RQ10: Edge to active bit takes at least three core cycles.
// RQ11: Supervisor reads latch; a write cancels a latched event only when unmasked-off; code cancels only masked-off levels 5 to 15.
// RQ12: Only mask-enabled latched events are serviced; masked ones stay latched.
// RQ13: Global enable and disable of general interrupts, independent of mask bits.
// RQ14: Active register shows active or nested events, updated by hardware only.
// RQ15: Peripheral mask bit set passes the source, clear blocks it.
// RQ16: Peripheral status shows which sources are asserting now.
// RQ17: Wake-enabled source asserting while core idles wakes the processor.
// RQ18: Active bits acknowledge shared sources; overlapping pulses are all kept.
// RQ19: All six control and status registers are 32 bits wide.
// RQ20: Each event has its own return path; taking an event signals state save.
// RQ21: Nonmaskable event comes from watchdog or the external nonmaskable pin.
// RQ22: Exceptions are synchronous to program flow, taken before the instruction completes.
// RQ23: Registers answer only in supervisor mode; others see reserved space.
// RQ24: Start an event only above every active one; return clears its bit.
// RQ25: Among eligible events, the lowest level number wins.
package tsec_pkg;
  localparam int NLVL   = 16;
  localparam int NGEN   = 9;
  localparam int GFIRST = 7;
  localparam int RW     = 32;
  // Register indices
  localparam logic [3:0] R_LATCH = 4'h0;
  localparam logic [3:0] R_MASK  = 4'h1;
  localparam logic [3:0] R_ACT   = 4'h2;
  localparam logic [3:0] R_SMASK = 4'h3;
  localparam logic [3:0] R_STAT  = 4'h4;
  localparam logic [3:0] R_WAKE  = 4'h5;
  localparam logic [3:0] R_ASG0  = 4'h6;
  localparam logic [3:0] R_ASG2  = 4'h8;
  // Fixed levels
  localparam int L_EMUL = 0;
  localparam int L_RST = 1;
  localparam int L_NMI = 2;
  localparam int L_EXC = 3;
  localparam int L_HWE = 5;
  localparam int L_TMR = 6;
  // Levels 0 to 4 ignore the mask; levels 7 to 15 obey global enable
  localparam logic [15:0] NOMASK  = 16'h001f;
  localparam logic [15:0] GENLVL  = 16'hff80;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [95:0] ASG_RST = {32'h66655444, 32'h33322221, 32'h10000000};
  localparam int EDGE_CYC = 2;
  localparam int MIN_LAT  = 3;

  typedef struct packed {
    logic emul;
    logic rst;
    logic nmi_wdog;
    logic exc;
    logic hwerr;
    logic tmr;
  } tsec_core_evt_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sup;
    logic [3:0]  idx;
    logic [31:0] wdata;
  } tsec_reg_req_t;
endpackage : tsec_pkg

// ===== hdl/tsec_event_ctrl.sv
// Purpose: System routing stage plus core latch, mask and nesting stage
// Assumes: Peripheral lines and the nonmaskable pin are asynchronous
// Notes:   Core event inputs other than the pin come from core logic
`timescale 1ns/1ps
module tsec_event_ctrl #(
  parameter int NSRC = 24
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // Peripheral and core event sources
  input  wire logic [NSRC-1:0]         periph_irq,
  input  wire logic                    nmi_pin,
  input  wire tsec_pkg::tsec_core_evt_t core_evt,
  input  wire logic [tsec_pkg::NGEN-1:0] sw_raise,
  // Pipeline controls
  input  wire logic                    gie_set,
  input  wire logic                    gie_clr,
  input  wire logic                    evt_return,
  input  wire logic                    core_idle,
  // Register port
  input  wire tsec_pkg::tsec_reg_req_t reg_req,
  output logic [31:0]                  rdata_q,
  output logic                         rvalid_q,
  output logic                         acc_err_q,
  // Event outputs
  output logic                         take_q,
  output logic [3:0]                   take_lvl_q,
  output logic [15:0]                  active_q,
  output logic                         wake_q
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [4:0] first1(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : first1

  function automatic logic [31:0] pad(input logic [NSRC-1:0] v);
    logic [31:0] r;
    r = 32'h0;
    r[NSRC-1:0] = v;
    return r;
  endfunction : pad

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NSRC-1:0] p_s1_q;
  logic [NSRC-1:0] p_s2_q;
  logic            nmi_s1_q;
  logic            nmi_s2_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      p_s1_q   <= '0;
      p_s2_q   <= '0;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
    end else begin
      p_s1_q   <= periph_irq;
      p_s2_q   <= p_s1_q;
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
    end
  end

  // ************************************************************
  // Register state
  // ************************************************************
  logic [15:0]     latch_q;
  logic [15:0]     mask_q;
  logic [NSRC-1:0] smask_q;
  logic [NSRC-1:0] wake_en_q;
  logic [3:0]      lvl_q [NSRC];
  logic            gie_q;
  logic            sup_wr;
  logic [3:0]      asg_k;

  assign sup_wr = reg_req.wr && reg_req.sup;  // see RQ23
  assign asg_k  = reg_req.idx - tsec_pkg::R_ASG0;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_q    <= tsec_pkg::MASK_RST;
      smask_q   <= '0;
      wake_en_q <= '0;
    end else if (sup_wr) begin
      case (reg_req.idx)
        tsec_pkg::R_MASK:  mask_q    <= reg_req.wdata[15:0];     // see RQ12
        tsec_pkg::R_SMASK: smask_q   <= reg_req.wdata[NSRC-1:0]; // see RQ15
        tsec_pkg::R_WAKE:  wake_en_q <= reg_req.wdata[NSRC-1:0]; // see RQ17
        default: begin
        end
      endcase
    end
  end

  // Eight four-bit level fields per assignment word
  always_ff @(posedge ref_clk) begin
    for (int s = 0; s < NSRC; s++) begin
      if (reset) begin
        lvl_q[s] <= tsec_pkg::ASG_RST[s*4 +: 4];  // see RQ6
      end else if (sup_wr && reg_req.idx >= tsec_pkg::R_ASG0 &&
                   reg_req.idx <= tsec_pkg::R_ASG2 && int'(asg_k) == s / 8) begin
        lvl_q[s] <= reg_req.wdata[(s % 8)*4 +: 4];  // see RQ5
      end
    end
  end

  // Set wins so a global enable is never lost to a same-cycle disable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gie_q <= 1'b1;
    end else if (gie_set) begin
      gie_q <= 1'b1;  // see RQ13
    end else if (gie_clr) begin
      gie_q <= 1'b0;
    end
  end

  // ************************************************************
  // System stage: per-source capture and routing
  // ************************************************************
  logic [NSRC-1:0] p_prev_q;
  logic [NSRC-1:0] src_pend_q;
  logic [NSRC-1:0] src_ack;
  logic [NSRC-1:0] src_new;
  logic [15:0]     act_prev_q;
  logic [15:0]     act_new;
  logic [tsec_pkg::NGEN-1:0] gen_req;
  logic [tsec_pkg::NGEN-1:0] gen_q;

  assign act_new = active_q & ~act_prev_q;
  assign src_new = p_s2_q & ~p_prev_q & smask_q;  // see RQ15

  // Each source keeps its own flag, so overlapping pulses on a shared
  // level survive until the level is acknowledged
  // Acknowledged level drops one cycle, so a flag set meanwhile makes a new edge
  always_comb begin
    src_ack = '0;
    gen_req = sw_raise;
    for (int s = 0; s < NSRC; s++) begin
      for (int k = 0; k < tsec_pkg::NGEN; k++) begin
        if (lvl_q[s] == 4'(k)) begin
          gen_req[k] = gen_req[k] | (src_pend_q[s] & ~act_new[tsec_pkg::GFIRST + k]);
          src_ack[s] = act_new[tsec_pkg::GFIRST + k];  // see RQ18
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      p_prev_q   <= '0;
      src_pend_q <= '0;
      act_prev_q <= '0;
      gen_q      <= '0;
    end else begin
      p_prev_q   <= p_s2_q;
      act_prev_q <= active_q;
      gen_q      <= gen_req;  // see RQ3
      src_pend_q <= (src_pend_q & ~src_ack) | src_new;  // see RQ15 RQ18
    end
  end

  // ************************************************************
  // Core stage: edge capture, latch, priority and nesting
  // ************************************************************
  logic [15:0] core_raw;
  logic [15:0] core_in_q;
  logic [15:0] core_prev_q;
  logic [15:0] rise;
  logic [15:0] elig;
  logic [4:0]  pick;
  logic [4:0]  top;
  logic        take;
  logic [15:0] take_oh;
  logic [15:0] ret_oh;
  logic [15:0] wr_cancel;

  always_comb begin
    core_raw = 16'h0;
    core_raw[tsec_pkg::L_EMUL] = core_evt.emul;
    core_raw[tsec_pkg::L_RST] = core_evt.rst;
    core_raw[tsec_pkg::L_NMI] = core_evt.nmi_wdog | nmi_s2_q;  // see RQ21
    core_raw[tsec_pkg::L_EXC] = core_evt.exc;  // see RQ22
    core_raw[tsec_pkg::L_HWE] = core_evt.hwerr;
    core_raw[tsec_pkg::L_TMR] = core_evt.tmr;
    core_raw[15:tsec_pkg::GFIRST] = gen_q;  // see RQ1 RQ3
  end

  assign rise = core_in_q & ~core_prev_q;  // see RQ7
  assign elig = latch_q & (mask_q | tsec_pkg::NOMASK) &
                (gie_q ? 16'hffff : ~tsec_pkg::GENLVL);  // see RQ12 RQ13
  assign pick = first1(elig);  // see RQ25
  assign top  = first1(active_q);
  // Only strictly higher priority may preempt
  assign take = pick[4] && (!top[4] || pick[3:0] < top[3:0]);  // see RQ24 RQ2
  assign take_oh = take ? (16'h1 << pick[3:0]) : 16'h0;
  assign ret_oh  = (evt_return && top[4]) ? (16'h1 << top[3:0]) : 16'h0;
  assign wr_cancel = (sup_wr && reg_req.idx == tsec_pkg::R_LATCH) ?
                     (reg_req.wdata[15:0] & ~(mask_q | tsec_pkg::NOMASK)) : 16'h0;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_in_q   <= '0;
      core_prev_q <= '0;
    end else begin
      core_in_q   <= core_raw;
      core_prev_q <= core_in_q;
    end
  end

  // New edges win over acceptance and cancel in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_q <= '0;
    end else begin
      latch_q <= (latch_q & ~take_oh & ~wr_cancel) | rise;  // see RQ8 RQ9 RQ11
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_q <= '0;
    end else begin
      active_q <= (active_q & ~ret_oh) | take_oh;  // see RQ14 RQ24 RQ20
    end
  end

  // Pulse tells the pipeline to save state and fetch this level's vector
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      take_q     <= 1'b0;
      take_lvl_q <= 4'h0;
    end else begin
      take_q     <= take;  // see RQ20
      take_lvl_q <= pick[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= core_idle && |(p_s2_q & wake_en_q);  // see RQ17
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    case (reg_req.idx)
      tsec_pkg::R_LATCH: rd_mux[15:0] = latch_q;  // see RQ11 RQ19
      tsec_pkg::R_MASK:  rd_mux[15:0] = mask_q | tsec_pkg::NOMASK;
      tsec_pkg::R_ACT:   rd_mux[15:0] = active_q;  // see RQ14
      tsec_pkg::R_SMASK: rd_mux = pad(smask_q);
      tsec_pkg::R_STAT:  rd_mux = pad(p_s2_q);  // see RQ16
      tsec_pkg::R_WAKE:  rd_mux = pad(wake_en_q);
      default: begin
        for (int s = 0; s < NSRC; s++) begin
          if (reg_req.idx >= tsec_pkg::R_ASG0 && reg_req.idx <= tsec_pkg::R_ASG2 &&
              int'(asg_k) == s / 8) begin
            rd_mux[(s % 8)*4 +: 4] = lvl_q[s];
          end
        end
      end
    endcase
  end

  // User-mode access sees reserved space: zero data, no effect
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q   <= 32'h0;
      rvalid_q  <= 1'b0;
      acc_err_q <= 1'b0;
    end else begin
      rvalid_q  <= reg_req.rd;
      rdata_q   <= (reg_req.rd && reg_req.sup) ? rd_mux : 32'h0;  // see RQ23
      acc_err_q <= (reg_req.rd || reg_req.wr) && !reg_req.sup;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_edge;
    rise != 16'h0;
  endsequence

  sequence s_started;
    act_new != 16'h0;
  endsequence

  chk_edge_latch: assert property (@(posedge ref_clk) disable iff (reset) // see RQ7
    s_edge |=> ((latch_q | active_q) & $past(rise)) == $past(rise))
    else $error("edge not latched");

  chk_latch_clear: assert property (@(posedge ref_clk) disable iff (reset) // see RQ8
    (take_oh & ~rise) != 16'h0 |=> (latch_q & $past(take_oh & ~rise)) == 16'h0)
    else $error("latch not cleared on start");

  chk_start_latched: assert property (@(posedge ref_clk) disable iff (reset) // see RQ10
    s_started |-> (act_new & ~$past(latch_q)) == 16'h0)
    else $error("event started without latch");

  chk_gen_latency: assert property (@(posedge ref_clk) disable iff (reset) // see RQ10
    $rose(gen_q[0]) && active_q[tsec_pkg::GFIRST] == 1'b0 ##1
      !active_q[tsec_pkg::GFIRST] |-> ##1 !active_q[tsec_pkg::GFIRST])
    else $error("general event active too early");

  chk_preempt_only: assert property (@(posedge ref_clk) disable iff (reset) // see RQ24
    s_started and ($past(active_q) != 16'h0) |->
      first1(act_new) < first1($past(active_q)) + 5'h0)
    else $error("event started below an active one");

  chk_lowest_pick: assert property (@(posedge ref_clk) disable iff (reset) // see RQ25
    s_started |-> first1(act_new) == first1($past(elig)))
    else $error("not the lowest eligible level");

  chk_mask_block: assert property (@(posedge ref_clk) disable iff (reset) // see RQ12
    (act_new & ~$past(mask_q | tsec_pkg::NOMASK)) == 16'h0)
    else $error("masked event serviced");

  chk_global_off: assert property (@(posedge ref_clk) disable iff (reset) // see RQ13
    !$past(gie_q) |-> (act_new & tsec_pkg::GENLVL) == 16'h0)
    else $error("general event while globally disabled");

  chk_user_write: assert property (@(posedge ref_clk) disable iff (reset) // see RQ23
    reg_req.wr && !reg_req.sup |=> $stable(mask_q) && $stable(smask_q) && $stable(wake_en_q))
    else $error("user write changed a register");

  chk_wake_path: assert property (@(posedge ref_clk) disable iff (reset) // see RQ17
    wake_q |-> $past(core_idle) && $past(p_s2_q & wake_en_q) != '0)
    else $error("wake without enabled source");

  chk_take_marks: assert property (@(posedge ref_clk) disable iff (reset) // see RQ20
    take_q |-> $past(take) && active_q[take_lvl_q])
    else $error("start pulse without active level");

  chk_return_clears: assert property (@(posedge ref_clk) disable iff (reset) // see RQ24
    evt_return && top[4] |=> !active_q[$past(top[3:0])])
    else $error("return left its level active");

  chk_ack_flags: assert property (@(posedge ref_clk) disable iff (reset) // see RQ18
    (src_ack & ~src_new) != '0 |=> (src_pend_q & $past(src_ack & ~src_new)) == '0)
    else $error("acknowledged source flag kept");

  chk_level_rearm: assert property (@(posedge ref_clk) disable iff (reset) // see RQ9
    act_new[15:tsec_pkg::GFIRST] != '0 |=>
      (gen_q & $past(act_new[15:tsec_pkg::GFIRST] & ~sw_raise)) == '0)
    else $error("acknowledged level not dropped");

  chk_cancel_masked: assert property (@(posedge ref_clk) disable iff (reset) // see RQ11
    sup_wr && reg_req.idx == tsec_pkg::R_LATCH |=>
      ($past(latch_q & ~take_oh & (mask_q | tsec_pkg::NOMASK)) & ~latch_q) == 16'h0)
    else $error("write cancelled an unmasked event");

  chk_user_read: assert property (@(posedge ref_clk) disable iff (reset) // see RQ23
    reg_req.rd && !reg_req.sup |=> rdata_q == 32'h0 && acc_err_q)
    else $error("user read not refused");

endmodule : tsec_event_ctrl

// ===== tb/tsec_src_model.sv
// Purpose: Peripheral interrupt sources seen by the event controller
// Assumes: Active-high level requests, idle low between requests
// Notes:   One source at a time, held for a commanded number of cycles
`timescale 1ns/1ps
module tsec_src_model #(
  parameter int NSRC = 24
) (
  // Clock
  input  wire logic            ref_clk,
  // Request lines
  output logic [NSRC-1:0]      periph_irq
);
  int src_sel = 0;
  int hold_n  = 0;

  initial periph_irq = '0;

  // Called after a rising edge; picked up at the next falling edge
  task automatic start(input int s, input int n);
    src_sel = s;
    hold_n  = n;
  endtask : start

  // Line returns to its inactive level once the hold runs out
  always @(negedge ref_clk) begin
    periph_irq <= (hold_n > 0) ? (NSRC'(1) << src_sel) : '0;
    if (hold_n > 0) begin
      hold_n <= hold_n - 1;
    end
  end
endmodule : tsec_src_model

// ===== tb/test_two_stage_event_controller.sv
// Purpose: Self-checking bench of the two-stage event controller
// Assumes: Supervisor register port, 200 MHz core clock
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
module test_two_stage_event_controller;
  logic                     ref_clk = 1'b0;
  logic                     reset   = 1'b1;
  logic [23:0]              periph_irq;
  logic                     nmi_pin = 1'b0;
  tsec_pkg::tsec_core_evt_t core_evt = '0;
  logic [8:0]               sw_raise = '0;
  logic                     gie_set = 1'b0;
  logic                     gie_clr = 1'b0;
  logic                     evt_return = 1'b0;
  logic                     core_idle = 1'b0;
  tsec_pkg::tsec_reg_req_t  reg_req = '0;
  logic [31:0]              rdata_q;
  logic                     rvalid_q, acc_err_q, take_q, wake_q;
  logic [3:0]               take_lvl_q;
  logic [15:0]              active_q;
  int                       n_errors = 0;
  int                       tests_run = 0;
  int                       cyc = 0;
  int                       lat;

  always #2.5 ref_clk = ~ref_clk;

  tsec_src_model #(.NSRC(24)) mdl (.ref_clk(ref_clk), .periph_irq(periph_irq));

  tsec_event_ctrl #(.NSRC(24)) dut (
    .ref_clk(ref_clk), .reset(reset), .periph_irq(periph_irq), .nmi_pin(nmi_pin),
    .core_evt(core_evt), .sw_raise(sw_raise), .gie_set(gie_set), .gie_clr(gie_clr),
    .evt_return(evt_return), .core_idle(core_idle), .reg_req(reg_req),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .acc_err_q(acc_err_q), .take_q(take_q),
    .take_lvl_q(take_lvl_q), .active_q(active_q), .wake_q(wake_q));

  // ***************
  // Shared tasks
  // ***************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Hang guard well above the couple of hundred cycles the scenarios need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] idx, input logic [31:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, sup: 1'b1, idx: idx, wdata: d};
    @(negedge ref_clk);
    reg_req = '0;
    @(negedge ref_clk);
  endtask : reg_wr

  // Answer stands from the taking edge and is checked at the next falling edge
  task automatic reg_rd(input logic [3:0] idx, input logic sup, input logic [31:0] exp);
    reg_req = '{wr: 1'b0, rd: 1'b1, sup: sup, idx: idx, wdata: 32'h0};
    @(negedge ref_clk);
    reg_req = '0;
    chk("read valid", 32'h1, {31'h0, rvalid_q});
    chk("access error", {31'h0, ~sup}, {31'h0, acc_err_q});
    chk("read data", sup ? exp : 32'h0, rdata_q);
    @(negedge ref_clk);
  endtask : reg_rd

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
    @(negedge ref_clk);
  endtask : pulse

  task automatic raise(input logic [8:0] b);
    sw_raise = b;
    @(negedge ref_clk);
    sw_raise = '0;
    @(negedge ref_clk);
  endtask : raise

  task automatic wait_take(input logic [3:0] lvl);
    lat = 0;
    while (take_q !== 1'b1 && lat < 20) begin
      @(negedge ref_clk);
      lat++;
    end
    chk("take seen", 32'h1, {31'h0, take_q});
    chk("take level", {28'h0, lvl}, {28'h0, take_lvl_q});
    @(negedge ref_clk);
  endtask : wait_take

  task automatic no_take;
    repeat (15) begin
      @(negedge ref_clk);
      chk("no take", 32'h0, {31'h0, take_q});
    end
  endtask : no_take

  // ***************
  // Scenarios
  // ***************
  task automatic t_reset_regs;
    logic [31:0] asg [3] = '{32'h10000000, 32'h33322221, 32'h66655444};
    reg_rd(tsec_pkg::R_MASK, 1'b1, 32'h0000001f);
    reg_rd(tsec_pkg::R_ACT, 1'b1, 32'h0);
    reg_rd(tsec_pkg::R_SMASK, 1'b1, 32'h0);
    reg_rd(tsec_pkg::R_WAKE, 1'b1, 32'h0);
    for (int i = 0; i < 3; i++) reg_rd(4'(6 + i), 1'b1, asg[i]);
    reg_rd(4'h9, 1'b1, 32'h0);
    reg_rd(tsec_pkg::R_MASK, 1'b0, 32'h0);
    reg_req = '{wr: 1'b1, rd: 1'b0, sup: 1'b0, idx: tsec_pkg::R_MASK, wdata: 32'hffffffff};
    @(negedge ref_clk);
    reg_req = '0;
    chk("write error", 32'h1, {31'h0, acc_err_q});
    @(negedge ref_clk);
    reg_rd(tsec_pkg::R_MASK, 1'b1, 32'h0000001f);
  endtask : t_reset_regs

  task automatic t_core_timer;
    reg_wr(tsec_pkg::R_MASK, 32'h00000040);
    core_evt.tmr = 1'b1;
    repeat (2) begin
      @(negedge ref_clk);
      chk("early active", 32'h0, {16'h0, active_q});
    end
    wait_take(4'h6);
    chk("active timer", 32'h00000040, {16'h0, active_q});
    reg_rd(tsec_pkg::R_LATCH, 1'b1, 32'h0);
    core_evt.tmr = 1'b0;
    pulse(evt_return);
    @(negedge ref_clk);
    chk("return clears", 32'h0, {16'h0, active_q});
  endtask : t_core_timer

  task automatic t_periph;
    reg_wr(tsec_pkg::R_SMASK, 32'h00010000);
    reg_wr(tsec_pkg::R_WAKE, 32'h00010000);
    reg_wr(tsec_pkg::R_MASK, 32'h00000800);
    core_idle = 1'b1;
    @(posedge ref_clk) mdl.start(16, 8);
    repeat (5) @(negedge ref_clk);
    chk("wake", 32'h1, {31'h0, wake_q});
    reg_rd(tsec_pkg::R_STAT, 1'b1, 32'h00010000);
    wait_take(4'hb);
    core_idle = 1'b0;
    pulse(evt_return);
    @(posedge ref_clk) mdl.start(17, 8);
    no_take();
  endtask : t_periph

  task automatic t_mask_cancel;
    reg_wr(tsec_pkg::R_MASK, 32'h0);
    raise(9'h001);
    no_take();
    reg_rd(tsec_pkg::R_LATCH, 1'b1, 32'h00000080);
    reg_wr(tsec_pkg::R_LATCH, 32'h00000080);
    reg_rd(tsec_pkg::R_LATCH, 1'b1, 32'h0);
  endtask : t_mask_cancel

  task automatic t_global;
    reg_wr(tsec_pkg::R_MASK, 32'h00000100);
    pulse(gie_clr);
    raise(9'h002);
    no_take();
    pulse(gie_set);
    wait_take(4'h8);
    pulse(evt_return);
  endtask : t_global

  // Software raises stay below 14 and 15, kept for handler use
  task automatic t_nesting;
    reg_wr(tsec_pkg::R_MASK, 32'h00000700);
    raise(9'h008);
    wait_take(4'ha);
    raise(9'h006);
    wait_take(4'h8);
    pulse(nmi_pin);
    wait_take(4'h2);
    chk("nested set", 32'h00000504, {16'h0, active_q});
    pulse(evt_return);
    pulse(evt_return);
    wait_take(4'h9);
    chk("after returns", 32'h00000600, {16'h0, active_q});
    pulse(evt_return);
    pulse(evt_return);
    @(negedge ref_clk);
    chk("all returned", 32'h0, {16'h0, active_q});
  endtask : t_nesting

  initial begin
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_reset_regs();
    t_core_timer();
    t_periph();
    t_mask_cancel();
    t_global();
    t_nesting();
    give_verdict();
  end
endmodule : test_two_stage_event_controller
